/* File: adc_control_two_logic_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_control_two_logic_tb;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, rv;
  logic [3:0]  conv_idx, result_idx, trig_channel, k;
  logic [15:0] conversion_complete_flag, input_buffer_en;
  logic        clk_sys, rst_n, reg_wr, reg_rd, seq_busy, sequence_complete_flag, conv_done;
  logic        status_one_read, result_access, result_is_read, wait_mode, trigger_inputs;
  logic        trig_src_is_channel, seq_abort, seq_start, conv_halt, analog_power_en;
  logic        conversions_valid, resumed_suspect, irq_req;
  int          n_mismatch, n_tests, c, i;
  integer      seed = 32'h3ce7a040;

  adcc2_ctrl u_dut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // One-cycle pulse of done, status read or result access on slot x
  task automatic ev(input logic [2:0] w, input logic [3:0] x, input logic r);
    @(posedge clk_sys);
    {conv_done, status_one_read, result_access} <= w;
    conv_idx <= x;
    result_idx <= x;
    result_is_read <= r;
    @(posedge clk_sys);
    {conv_done, status_one_read, result_access} <= 3'b000;
  endtask

  task automatic starts(input int n);
    c = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 if (seq_start === 1'b1) c++;
    end
  endtask

  function automatic logic [7:0] exp_ctl(input logic [7:0] w, input logic seq_done);
    return {w[7:1], w[1] & seq_done};
  endfunction

  initial begin
    {reg_wr, reg_rd, seq_busy, sequence_complete_flag, conv_done, status_one_read} = '0;
    {result_access, result_is_read, wait_mode, trigger_inputs, trig_src_is_channel} = '0;
    {reg_addr, reg_wdata, conv_idx, result_idx, trig_channel} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(adcc2_pkg::CTL2_OFFSET);
    chk("ctl2 reset", rv, adcc2_pkg::CTL2_RESET);
    for (i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'($random(seed));
      @(posedge clk_sys);
      {trig_src_is_channel, trig_channel, sequence_complete_flag} <= 6'($random(seed));
      wr(adcc2_pkg::CTL2_OFFSET, d);
      #1 chk("abort", seq_abort, 1'b1);
      wr(8'h05, ~d);
      rd(adcc2_pkg::CTL2_OFFSET);
      chk("ctl2 readback", rv, exp_ctl(d, sequence_complete_flag));
      chk("irq", irq_req, d[1] & sequence_complete_flag);
      chk("buffer", input_buffer_en, (d[2] & trig_src_is_channel) ? 16'h0001 << trig_channel : 16'h0000);
      rd(8'h05);
      chk("unmapped", rv, 8'h00);
    end
    wr(adcc2_pkg::CTL2_OFFSET, 8'h00);
    wr(adcc2_pkg::CTL2_OFFSET, 8'ha0);
    repeat (adcc2_pkg::RECOVERY_CYC - 5) @(posedge clk_sys);
    #1 chk("early valid", conversions_valid, 1'b0);
    repeat (10) @(posedge clk_sys);
    #1 chk("valid", conversions_valid, 1'b1);
    @(posedge clk_sys);
    wait_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("halt", {conv_halt, analog_power_en}, 2'b10);
    @(posedge clk_sys);
    wait_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("resume", {resumed_suspect, conversions_valid}, 2'b10);
    rd(adcc2_pkg::PWR_STAT_OFFSET);
    chk("power status", rv, 8'((1 << adcc2_pkg::PWR_ANALOG_BIT) | (1 << adcc2_pkg::PWR_SUSPECT_BIT)));
    ev(3'b100, 4'h3, 1'b0);
    @(posedge clk_sys);
    #1 chk("suspect cleared", resumed_suspect, 1'b0);
    for (i = 0; i < 6; i++) begin
      k = 4'($random(seed));
      wr(adcc2_pkg::CTL2_OFFSET, {1'b1, i[0], 6'h00});
      ev(3'b100, k, 1'b0);
      rd(k[3] ? adcc2_pkg::CONV_FLAG_HI_OFFSET : adcc2_pkg::CONV_FLAG_LO_OFFSET);
      chk("flag readback", rv[k[2:0]], 1'b1);
      // Fast mode uses a write access: any access must clear
      ev(3'b001, k, ~i[0]);
      #1 chk("flag after access", conversion_complete_flag[k], 1'(~i[0]));
      if (!i[0]) begin
        ev(3'b010, k, 1'b1);
        ev(3'b001, k, 1'b1);
        #1 chk("flag normal clear", conversion_complete_flag[k], 1'b0);
      end
    end
    // Fifth pass repeats the falling edge with the trigger disabled
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      trigger_inputs <= ~i[0];
      wr(adcc2_pkg::CTL2_OFFSET, {3'b100, i[1], i[0], i < 4, 2'b00});
      starts(6);
      @(posedge clk_sys);
      trigger_inputs <= i[0];
      starts(10);
      chk("trigger start", 16'(c), (i == 4) ? 16'h0 : i[1] ? 16'h8 : 16'h1);
      @(posedge clk_sys);
      trigger_inputs <= ~i[0];
      starts(i[1] ? 5 : 0);
      starts(8);
      chk("inactive start", 16'(c), 16'h0);
    end
    // Sequencer busy holds off a level trigger that is otherwise active
    @(posedge clk_sys);
    seq_busy <= 1'b1;
    wr(adcc2_pkg::CTL2_OFFSET, 8'h9c);
    starts(8);
    chk("busy start", 16'(c), 16'h0);
    @(posedge clk_sys);
    seq_busy <= 1'b0;
    starts(4);
    chk("idle start", 16'(c), 16'h4);
    // Without wait power-down the converter keeps running in wait mode
    @(posedge clk_sys);
    wait_mode <= 1'b1;
    @(posedge clk_sys);
    #1 chk("wait run", {conv_halt, analog_power_en}, 2'b01);
    end_sim;
  end

  initial begin
    #(40 * 10000);
    n_mismatch++;
    end_sim;
  end
endmodule

`default_nettype wire

/* File: adcc2_ctrl.sv */
//What this block does
// - Any write to control register two aborts the sequence and never starts one.
// - Power bit 7 off powers down; after power-up wait recovery before valid.
// - Fast clear off: flag clears on status-one read then result read.
// - Fast clear on: any result access clears that result's complete flag.
// - Wait power-down bit 5: run in wait, or halt and power down.
// - Leaving wait resumes halted conversion; that result is marked suspect.
// - Sensitivity bit 4 picks edge at 0, level at 1.
// - Polarity bit 3 picks falling/low at 0, rising/high at 1.
// - Enable bit 2 gates trigger; channel source enables its input buffer.
// - An enabled trigger starts conversion three clocks after the external event, past a two-stage synchroniser.
// - Interrupt enable bit 1 raises a request whenever the flag is set.
// - Flag bit 0 mirrors sequence complete when enabled, else reads zero.
// - Writes to flag bit 0 have no effect; it is derived.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adcc2_ctrl (
  // Clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  // Register port
  input  wire logic [7:0]                            reg_addr,
  input  wire logic [7:0]                            reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [7:0]                            reg_rdata,
  // Sequencer side
  input  wire logic                                  seq_busy,
  input  wire logic                                  sequence_complete_flag,
  input  wire logic                                  conv_done,
  input  wire logic [adcc2_pkg::CHAN_W-1:0]          conv_idx,
  output logic                                       seq_abort,
  output logic                                       seq_start,
  output logic                                       conv_halt,
  // Result and status access
  input  wire logic                                  status_one_read,
  input  wire logic                                  result_access,
  input  wire logic                                  result_is_read,
  input  wire logic [adcc2_pkg::CHAN_W-1:0]          result_idx,
  output logic      [adcc2_pkg::NUM_CHANNELS-1:0]    conversion_complete_flag,
  // Power and mode
  input  wire logic                                  wait_mode,
  output logic                                       analog_power_en,
  output logic                                       conversions_valid,
  output logic                                       resumed_suspect,
  // External trigger
  input  wire logic                                  trigger_inputs,
  input  wire logic                                  trig_src_is_channel,
  input  wire logic [adcc2_pkg::CHAN_W-1:0]          trig_channel,
  output logic      [adcc2_pkg::NUM_CHANNELS-1:0]    input_buffer_en,
  // Interrupt request
  output logic                                       irq_req
);

  typedef struct packed {
    logic                                   converter_power_on;
    logic                                   fast_flag_clear;
    logic                                   wait_power_down;
    logic                                   trigger_level_select;
    logic                                   trigger_polarity;
    logic                                   trigger_enable_bit;
    logic                                   sequence_irq_enable;
    logic [7:0]                             rdata;
    logic [adcc2_pkg::NUM_CHANNELS-1:0]     cflag;
    logic [adcc2_pkg::NUM_CHANNELS-1:0]     armed;
    logic [adcc2_pkg::REC_W-1:0]            rec_cnt;
    logic                                   pwr_prev;
    logic                                   halt_prev;
    logic                                   valid;
    logic                                   suspect;
    logic                                   abort;
    logic                                   start;
  } adcc2_state_s;

  adcc2_state_s                        st_q;
  adcc2_state_s                        st_d;
  logic                                ctl_wr;
  logic                                halt_now;
  logic                                pwr_now;
  logic                                sequence_irq_flag;
  logic [adcc2_pkg::NUM_CHANNELS-1:0]  cflag_set;
  logic [adcc2_pkg::NUM_CHANNELS-1:0]  cflag_clr;

  adcc2_trig_if trig_bus ();

  function automatic logic [adcc2_pkg::NUM_CHANNELS-1:0] onehot(input logic [adcc2_pkg::CHAN_W-1:0] idx);
    logic [adcc2_pkg::NUM_CHANNELS-1:0] v;
    v      = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  function automatic logic [7:0] ctl_image(input adcc2_state_s s, input logic flag);
    logic [7:0] v;
    v                               = adcc2_pkg::CTL2_RESET;
    v[adcc2_pkg::POWER_ON_BIT]      = s.converter_power_on;
    v[adcc2_pkg::FAST_CLEAR_BIT]    = s.fast_flag_clear;
    v[adcc2_pkg::WAIT_PD_BIT]       = s.wait_power_down;
    v[adcc2_pkg::LEVEL_SEL_BIT]     = s.trigger_level_select;
    v[adcc2_pkg::POLARITY_BIT]      = s.trigger_polarity;
    v[adcc2_pkg::TRIG_ENABLE_BIT]   = s.trigger_enable_bit;
    v[adcc2_pkg::IRQ_ENABLE_BIT]    = s.sequence_irq_enable;
    v[adcc2_pkg::IRQ_FLAG_BIT]      = flag;
    return v;
  endfunction

  assign ctl_wr   = reg_wr & (reg_addr == adcc2_pkg::CTL2_OFFSET);
  assign halt_now = wait_mode & st_q.wait_power_down;
  assign pwr_now  = st_q.converter_power_on & ~halt_now;

  assign sequence_irq_flag = st_q.sequence_irq_enable & sequence_complete_flag;

  assign trig_bus.trig_pin  = trigger_inputs;
  assign trig_bus.level_sel = st_q.trigger_level_select;
  assign trig_bus.polarity  = st_q.trigger_polarity;
  assign trig_bus.enable    = st_q.trigger_enable_bit;
  assign trig_bus.seq_busy  = seq_busy;

  adcc2_trig_detect u_trig_detect (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .trig    (trig_bus.detect)
  );

  // Flag set and clear terms for the conversion-complete flags
  always_comb begin
    cflag_set = conv_done ? onehot(conv_idx) : '0;
    cflag_clr = '0;
    if (result_access) begin
      if (st_q.fast_flag_clear) begin
        cflag_clr = onehot(result_idx);
      end else if (result_is_read) begin
        cflag_clr = onehot(result_idx) & st_q.armed;
      end
    end
  end

  always_comb begin
    st_d = st_q;

    if (ctl_wr) begin
      // Flag bit is derived, so bit 0 of the write data is dropped
      st_d.converter_power_on   = reg_wdata[adcc2_pkg::POWER_ON_BIT];
      st_d.fast_flag_clear      = reg_wdata[adcc2_pkg::FAST_CLEAR_BIT];
      st_d.wait_power_down      = reg_wdata[adcc2_pkg::WAIT_PD_BIT];
      st_d.trigger_level_select = reg_wdata[adcc2_pkg::LEVEL_SEL_BIT];
      st_d.trigger_polarity     = reg_wdata[adcc2_pkg::POLARITY_BIT];
      st_d.trigger_enable_bit   = reg_wdata[adcc2_pkg::TRIG_ENABLE_BIT];
      st_d.sequence_irq_enable  = reg_wdata[adcc2_pkg::IRQ_ENABLE_BIT];
    end

    st_d.abort = ctl_wr;
    // Trigger start is suppressed in the write cycle, so a write never launches a sequence
    st_d.start = trig_bus.start_req & ~ctl_wr & pwr_now & ~seq_busy;

    // Set wins over clear for the same flag in the same cycle
    st_d.cflag = (st_q.cflag & ~cflag_clr) | cflag_set;
    st_d.armed = st_q.armed & ~cflag_clr & ~cflag_set;
    if (status_one_read) begin
      st_d.armed = (st_q.armed & ~cflag_clr) | st_q.cflag;
    end

    // Recovery timer restarts on every power-up edge, including wait exit
    st_d.pwr_prev = pwr_now;
    if (!pwr_now) begin
      st_d.valid   = 1'b0;
      st_d.rec_cnt = '0;
    end else if (!st_q.pwr_prev) begin
      st_d.valid   = 1'b0;
      st_d.rec_cnt = adcc2_pkg::REC_W'(adcc2_pkg::RECOVERY_CYC);
    end else if (st_q.rec_cnt != '0) begin
      st_d.rec_cnt = st_q.rec_cnt - 1'b1;
      st_d.valid   = 1'b0;
    end else begin
      st_d.valid   = 1'b1;
    end

    // The conversion resumed after wait exit is flagged so software can drop it
    st_d.halt_prev = halt_now;
    if (st_q.halt_prev && !halt_now) begin
      st_d.suspect = 1'b1;
    end else if (conv_done) begin
      st_d.suspect = 1'b0;
    end

    st_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        adcc2_pkg::CTL2_OFFSET: begin
          st_d.rdata = ctl_image(st_q, sequence_irq_flag);
        end
        adcc2_pkg::CONV_FLAG_LO_OFFSET: begin
          st_d.rdata = st_q.cflag[7:0];
        end
        adcc2_pkg::CONV_FLAG_HI_OFFSET: begin
          st_d.rdata = st_q.cflag[15:8];
        end
        adcc2_pkg::PWR_STAT_OFFSET: begin
          st_d.rdata                             = 8'h00;
          st_d.rdata[adcc2_pkg::PWR_VALID_BIT]   = st_q.valid;
          st_d.rdata[adcc2_pkg::PWR_SUSPECT_BIT] = st_q.suspect;
          st_d.rdata[adcc2_pkg::PWR_ANALOG_BIT]  = pwr_now;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Input buffer is needed only when an analog channel serves as trigger
  always_comb begin
    input_buffer_en = '0;
    if (st_q.trigger_enable_bit && trig_src_is_channel) begin
      input_buffer_en = onehot(trig_channel);
    end
  end

  assign reg_rdata                = st_q.rdata;
  assign seq_abort                = st_q.abort;
  assign seq_start                = st_q.start;
  assign conv_halt                = halt_now;
  assign conversion_complete_flag = st_q.cflag;
  assign analog_power_en          = pwr_now;
  assign conversions_valid        = st_q.valid;
  assign resumed_suspect          = st_q.suspect;
  assign irq_req                  = sequence_irq_flag;

endmodule

`default_nettype wire

/* File: adcc2_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module adcc2_ctrl_assertions (
  // Clock and reset
  input wire logic                                clk_sys,
  input wire logic                                rst_n,
  // Register port
  input wire logic [7:0]                          reg_addr,
  input wire logic [7:0]                          reg_wdata,
  input wire logic                                reg_wr,
  input wire logic                                reg_rd,
  input wire logic [7:0]                          reg_rdata,
  // Sequencer, results and power
  input wire logic                                seq_busy,
  input wire logic                                sequence_complete_flag,
  input wire logic                                conv_done,
  input wire logic [adcc2_pkg::CHAN_W-1:0]        conv_idx,
  input wire logic                                seq_abort,
  input wire logic                                seq_start,
  input wire logic                                conv_halt,
  input wire logic                                result_access,
  input wire logic [adcc2_pkg::CHAN_W-1:0]        result_idx,
  input wire logic [adcc2_pkg::NUM_CHANNELS-1:0]  conversion_complete_flag,
  input wire logic                                wait_mode,
  input wire logic                                analog_power_en,
  input wire logic                                conversions_valid,
  // Trigger and interrupt
  input wire logic                                trig_src_is_channel,
  input wire logic [adcc2_pkg::CHAN_W-1:0]        trig_channel,
  input wire logic [adcc2_pkg::NUM_CHANNELS-1:0]  input_buffer_en,
  input wire logic                                irq_req
);
  logic [7:0] ctl_q;
  logic       wr_ctl;

  assign wr_ctl = reg_wr && (reg_addr == adcc2_pkg::CTL2_OFFSET);

  // Own copy of the written fields; bit 0 kept at zero since it is derived
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
    end else if (wr_ctl) begin
      ctl_q <= {reg_wdata[7:1], 1'b0};
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_abort_on_write: assert property (wr_ctl |=> seq_abort)
    else $error("no abort after control write");
  chk_abort_cause: assert property (seq_abort |-> $past(wr_ctl))
    else $error("abort without control write");
  chk_start_blocked: assert property ((wr_ctl || seq_busy || !analog_power_en) |=> !seq_start)
    else $error("start while blocked");
  chk_irq_mirror: assert property (irq_req == (ctl_q[1] && sequence_complete_flag))
    else $error("interrupt request wrong");
  chk_flag_read: assert property (reg_rd && reg_addr == adcc2_pkg::CTL2_OFFSET |=>
    reg_rdata == ($past(ctl_q) | {7'h00, $past(ctl_q[1] && sequence_complete_flag)}))
    else $error("control readback wrong");
  chk_halt_power: assert property (conv_halt == (wait_mode && ctl_q[5])
    && analog_power_en == (ctl_q[7] && !conv_halt))
    else $error("halt or power wrong");
  chk_power_valid: assert property (!ctl_q[7] |=> !conversions_valid)
    else $error("valid while powered down");
  chk_buffer_en: assert property (input_buffer_en ==
    ((ctl_q[2] && trig_src_is_channel) ? (16'h0001 << trig_channel) : 16'h0000))
    else $error("input buffer enable wrong");
  chk_trig_disabled: assert property ((!ctl_q[2]) [*4] |-> !seq_start)
    else $error("start with trigger disabled");
  chk_fast_clear: assert property (ctl_q[6] && result_access && !(conv_done && conv_idx == result_idx)
    |=> !conversion_complete_flag[$past(result_idx)])
    else $error("fast clear missed");
endmodule

bind adcc2_ctrl adcc2_ctrl_assertions u_chk (.*);

`default_nettype wire

/* File: adcc2_pkg.sv */
`default_nettype none

package adcc2_pkg;

  // Register map (plain port, byte offsets)
  localparam logic [7:0] CTL2_OFFSET         = 8'h02;
  localparam logic [7:0] CONV_FLAG_LO_OFFSET = 8'h20;
  localparam logic [7:0] CONV_FLAG_HI_OFFSET = 8'h21;
  localparam logic [7:0] PWR_STAT_OFFSET     = 8'h22;

  // Control register two field positions
  localparam int POWER_ON_BIT      = 7;
  localparam int FAST_CLEAR_BIT    = 6;
  localparam int WAIT_PD_BIT       = 5;
  localparam int LEVEL_SEL_BIT     = 4;
  localparam int POLARITY_BIT      = 3;
  localparam int TRIG_ENABLE_BIT   = 2;
  localparam int IRQ_ENABLE_BIT    = 1;
  localparam int IRQ_FLAG_BIT      = 0;

  // Power status register field positions
  localparam int PWR_VALID_BIT     = 0;
  localparam int PWR_SUSPECT_BIT   = 1;
  localparam int PWR_ANALOG_BIT    = 2;

  localparam logic [7:0] CTL2_RESET = 8'h00;

  // Number of result slots and conversion-complete flags
  localparam int NUM_CHANNELS = 16;
  localparam int CHAN_W       = 4;

  // Analog recovery time after power-up, counted at the system clock
  localparam int CLK_MHZ       = 25;
  localparam int RECOVERY_NS   = 20000;
  localparam int RECOVERY_CYC  = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_W         = $clog2(RECOVERY_CYC + 1);

endpackage

`default_nettype wire

/* File: adcc2_trig_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module adcc2_trig_detect (
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  // Trigger configuration and request
  adcc2_trig_if.detect  trig
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } adcc2_det_s;

  adcc2_det_s st_q;
  adcc2_det_s st_d;
  logic       edge_hit;
  logic       level_hit;

  always_comb begin
    st_d       = st_q;
    st_d.sync1 = trig.trig_pin;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.sync2;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edge from two successive synchronised samples
  always_comb begin
    edge_hit  = trig.polarity ? (st_q.sync2 & ~st_q.prev) : (~st_q.sync2 & st_q.prev);
    // Level keeps requesting while active, but only when the sequencer is idle
    level_hit = (st_q.sync2 == trig.polarity) & ~trig.seq_busy;
  end

  assign trig.start_req = trig.enable & (trig.level_sel ? level_hit : edge_hit);

endmodule

`default_nettype wire

/* File: adcc2_trig_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface adcc2_trig_if;
  logic trig_pin;
  logic level_sel;
  logic polarity;
  logic enable;
  logic seq_busy;
  logic start_req;

  modport ctrl (
    output trig_pin,
    output level_sel,
    output polarity,
    output enable,
    output seq_busy,
    input  start_req
  );

  modport detect (
    input  trig_pin,
    input  level_sel,
    input  polarity,
    input  enable,
    input  seq_busy,
    output start_req
  );
endinterface

`default_nettype wire
